// File: pkg/fpes_pkg.sv
/*
  constants and types shared by the flash command sequencer host.
  assumes a word-wide flash with command ports at sector base plus fixed word offsets.
*/
package fpes_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned SECT_W = 8;
  localparam int unsigned CNT_W = 9;
  // ---------------------------------------------------------------
  // command ports and codes
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FIRST_CMD_OFS = 24'h000555;
  localparam logic [ADDR_W-1:0] SECOND_CMD_OFS = 24'h000aaa;
  localparam logic [DATA_W-1:0] CMD_BITFIELD_LOAD = 16'h00bf;
  localparam logic [DATA_W-1:0] CMD_BUF_CONFIRM = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_PROG_SUSPEND = 16'h0051;
  localparam logic [DATA_W-1:0] CMD_PROG_RESUME = 16'h0050;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_ERASE_SUSPEND = 16'h00b0;
  localparam logic [DATA_W-1:0] CMD_ERASE_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] RESERVED_WORD = 16'hffff;
  localparam int unsigned RESV_ADDR_BIT = 3;
  localparam logic [CNT_W-1:0] MAX_WORDS = 9'h100;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned WRITE_PULSE_NS = 40;
  localparam int unsigned WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESUME_GAP_US = 100;
  localparam int unsigned RESUME_GAP_CYC = RESUME_GAP_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 16;
  // ---------------------------------------------------------------
  // request kinds
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FPES_OP_PROGRAM = 3'h0,
    FPES_OP_ERASE = 3'h1,
    FPES_OP_PSUSPEND = 3'h2,
    FPES_OP_PRESUME = 3'h3,
    FPES_OP_ESUSPEND = 3'h4,
    FPES_OP_ERESUME = 3'h5
  } fpes_op_t;
endpackage

// File: design/fpes_bus_write.sv
/*
  one flash write cycle: drives write enable low for a fixed pulse; chip enable is left to the caller.
  assumes address and data are held by the caller while busy is high.
*/
`timescale 1ns/1ps
`default_nettype none
module fpes_bus_write (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  output logic busy,
  output logic we_b
);
  import fpes_pkg::*;
  // ---------------------------------------------------------------
  // pulse timer
  // ---------------------------------------------------------------
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_busy;
  logic next_we_b;

  // count write pulse then one recovery cycle
  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    next_we_b = we_b;
    if (!busy && start) begin
      next_busy = 1'b1;
      next_we_b = 1'b0;
      next_cnt = 8'(WRITE_PULSE_CYC);
    end else if (busy) begin
      if (cnt > 8'h01) begin
        next_cnt = cnt - 8'h01;
      end else if (!we_b) begin
        next_we_b = 1'b1; // rising edge latches the word
        next_cnt = 8'h00;
      end else begin
        next_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      busy <= 1'b0;
      we_b <= 1'b1;
    end else begin
      cnt <= next_cnt;
      busy <= next_busy;
      we_b <= next_we_b;
    end
  end
endmodule // fpes_bus_write
`default_nettype wire

// File: design/fpes_host.sv
/*
  host-side command sequencer for a word-wide nor flash: bit-field program,
  sector erase, program and erase suspend and resume, issued as flash write cycles.
  assumes the flash samples address and data on the rising edge of we_b.
*/
// Functional notes
// R1: bit-field program opens with 00bf at sector plus 555.
// R2: second cycle writes word count minus one at sector plus aaa.
// R3: then between one and 256 address/data words are loaded.
// R4: confirm 0029 at sector plus 555 starts device programming.
// R5: words whose address bit three is set carry ffff.
// R6: fill the buffer with as many words as possible.
// R7: device halts programming within suspend latency on suspend.
// R8: program suspend is 0051 written at any address.
// R9: program resume is 0050 written at any address.
// R10: while program-suspended only reads, status read and resume are valid; the host still accepts erase suspend then.
// R11: program suspend is allowed in a program inside erase suspend.
// R12: after resume repeated resumes are ignored, new suspend allowed.
// R13: host keeps a minimum resume-to-suspend gap.
// R14: sector erase is 0080 at 555 then 0030 at aaa.
// R15: both erase cycles use the same sector address.
// R16: device erases itself with no host timing.
// R17: during erase only reads, status and erase suspend are valid; the host also accepts program suspend and resume then.
// R18: device returns bank to idle when erase ends; the host keeps erase_active set until reset.
// R19: after hardware reset the full erase sequence is reissued.
// R20: erase suspend acts only during sector erase.
// R21: erase-suspended device allows other-sector programs and erase resume; the host accepts programs to any sector then.
// R22: program inside erase suspend returns bank to erase suspend.
// R23: erase resume once, keeping the resume-to-suspend gap.
// R24: erase suspend is 00b0 written at any address.
// R25: erase resume is 0030 written at any address.
`timescale 1ns/1ps
`default_nettype none
module fpes_host (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire fpes_pkg::fpes_op_t req_op,
  input wire logic [fpes_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fpes_pkg::CNT_W-1:0] req_count,
  output logic req_ready,
  output logic word_req,
  input wire logic [fpes_pkg::DATA_W-1:0] word_data,
  output logic done,
  output logic refused,
  output logic erase_active,
  output logic erase_suspended,
  output logic prog_suspended,
  output logic [fpes_pkg::ADDR_W-1:0] flash_addr,
  output logic [fpes_pkg::DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_b,
  output logic flash_we_b
);
  import fpes_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    FPES_IDLE = 6'b000001,
    FPES_ISSUE = 6'b000010,
    FPES_WAIT = 6'b000100,
    FPES_FETCH = 6'b001000,
    FPES_NEXT = 6'b010000,
    FPES_DONE = 6'b100000
  } fpes_state_t;

  fpes_state_t state;
  fpes_state_t next_state;
  fpes_op_t op;
  fpes_op_t next_op;
  logic [3:0] step;
  logic [3:0] next_step;
  logic [CNT_W-1:0] left;
  logic [CNT_W-1:0] next_left;
  logic [CNT_W-1:0] total;
  logic [CNT_W-1:0] next_total;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [ADDR_W-1:0] waddr;
  logic [ADDR_W-1:0] next_waddr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] next_wdata;
  logic [TMR_W-1:0] gap;
  logic [TMR_W-1:0] next_gap;
  logic next_req_ready;
  logic next_word_req;
  logic next_done;
  logic next_refused;
  logic next_erase_active;
  logic next_erase_suspended;
  logic next_prog_suspended;
  logic next_dq_oe;
  logic next_ce_b;
  logic wr_start;
  logic wr_busy;
  logic wr_we_b;
  logic ok;

  // ---------------------------------------------------------------
  // write cycle engine
  // ---------------------------------------------------------------
  fpes_bus_write u_wr (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(wr_start),
    .busy(wr_busy),
    .we_b(wr_we_b)
  );

  // legality of a request against the tracked device state
  always_comb begin
    case (req_op)
      FPES_OP_PROGRAM: ok = (!erase_active || erase_suspended) && !prog_suspended; // see R17, see R10, see R21
      FPES_OP_ERASE: ok = !erase_active && !erase_suspended && !prog_suspended; // see R17
      FPES_OP_PSUSPEND: ok = !prog_suspended && gap == '0; // see R11, see R12, see R13
      FPES_OP_PRESUME: ok = prog_suspended; // see R12
      FPES_OP_ESUSPEND: ok = erase_active && !erase_suspended && gap == '0; // see R20, see R23
      FPES_OP_ERESUME: ok = erase_suspended && !prog_suspended; // see R23
      default: ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_left = left;
    next_total = total;
    next_base = base;
    next_waddr = waddr;
    next_wdata = wdata;
    next_gap = (gap != '0) ? gap - 1'b1 : gap;
    next_req_ready = 1'b0;
    next_word_req = 1'b0;
    next_done = 1'b0;
    next_refused = 1'b0;
    next_erase_active = erase_active;
    next_erase_suspended = erase_suspended;
    next_prog_suspended = prog_suspended;
    next_dq_oe = flash_dq_oe;
    next_ce_b = flash_ce_b;
    wr_start = 1'b0;
    case (state)
      FPES_IDLE: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_req_ready = 1'b0;
          if (!ok) begin
            next_refused = 1'b1;
          end else begin
            next_op = req_op;
            next_base = req_addr;
            next_step = 4'h0;
            next_left = (req_count == '0) ? CNT_W'(1) : ((req_count > MAX_WORDS) ? MAX_WORDS : req_count); // see R3, see R6
            next_total = next_left;
            next_state = FPES_NEXT;
          end
        end
      end
      FPES_NEXT: begin
        // choose the next write cycle of the sequence
        next_state = FPES_ISSUE;
        case (op)
          FPES_OP_PROGRAM: begin
            if (step == 4'h0) begin
              next_waddr = base + FIRST_CMD_OFS;
              next_wdata = CMD_BITFIELD_LOAD; // see R1
            end else if (step == 4'h1) begin
              next_waddr = base + SECOND_CMD_OFS;
              next_wdata = DATA_W'(left - 1'b1); // see R2
            end else if (step == 4'h2) begin
              next_state = FPES_FETCH;
              next_word_req = 1'b1;
            end else begin
              next_waddr = base + FIRST_CMD_OFS;
              next_wdata = CMD_BUF_CONFIRM; // see R4
            end
          end
          FPES_OP_ERASE: begin
            // same sector base on both cycles
            next_waddr = base + ((step == 4'h0) ? FIRST_CMD_OFS : SECOND_CMD_OFS); // see R15
            next_wdata = (step == 4'h0) ? CMD_ERASE_SETUP : CMD_SECTOR_ERASE; // see R14
          end
          FPES_OP_PSUSPEND: next_wdata = CMD_PROG_SUSPEND; // see R8
          FPES_OP_PRESUME: next_wdata = CMD_PROG_RESUME; // see R9
          FPES_OP_ESUSPEND: next_wdata = CMD_ERASE_SUSPEND; // see R24
          default: next_wdata = CMD_ERASE_RESUME; // see R25
        endcase
        if (op != FPES_OP_PROGRAM && op != FPES_OP_ERASE) begin
          next_waddr = base;
        end
      end
      FPES_FETCH: begin
        // data word arrives in the same cycle that word_req is high
        next_waddr = base + ADDR_W'(total - left); // word offset from the request base address
        next_wdata = next_waddr[RESV_ADDR_BIT] ? RESERVED_WORD : word_data; // see R5
        next_state = FPES_ISSUE;
      end
      FPES_ISSUE: begin
        next_ce_b = 1'b0;
        next_dq_oe = 1'b1;
        wr_start = 1'b1;
        next_state = FPES_WAIT;
      end
      FPES_WAIT: begin
        if (!wr_busy && flash_we_b) begin
          next_ce_b = 1'b1;
          next_dq_oe = 1'b0;
          next_state = FPES_NEXT;
          if (op == FPES_OP_PROGRAM && step == 4'h2) begin
            next_left = left - 1'b1;
            if (left == CNT_W'(1)) begin
              next_step = 4'h3;
            end
          end else if ((op == FPES_OP_PROGRAM && step == 4'h3) ||
                       (op == FPES_OP_ERASE && step == 4'h1) ||
                       (op != FPES_OP_PROGRAM && op != FPES_OP_ERASE)) begin
            next_state = FPES_DONE;
          end else begin
            next_step = step + 1'b1;
          end
        end
      end
      FPES_DONE: begin
        next_done = 1'b1;
        next_state = FPES_IDLE;
        case (op)
          FPES_OP_ERASE: next_erase_active = 1'b1; // see R16
          FPES_OP_PSUSPEND: next_prog_suspended = 1'b1; // see R7
          FPES_OP_PRESUME: begin
            next_prog_suspended = 1'b0;
            next_gap = TMR_W'(RESUME_GAP_CYC); // see R13
          end
          FPES_OP_ESUSPEND: next_erase_suspended = 1'b1; // see R20
          FPES_OP_ERESUME: begin
            next_erase_suspended = 1'b0;
            next_gap = TMR_W'(RESUME_GAP_CYC); // see R23
          end
          default: next_erase_active = erase_active; // see R22
        endcase
      end
      default: next_state = FPES_IDLE;
    endcase
  end

  // word addresses count up from the caller's base, so remember the start word address
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FPES_IDLE;
      op <= FPES_OP_PROGRAM;
      step <= 4'h0;
      left <= '0;
      total <= '0;
      base <= '0;
      waddr <= '0;
      wdata <= '0;
      gap <= '0;
      req_ready <= 1'b0;
      word_req <= 1'b0;
      done <= 1'b0;
      refused <= 1'b0;
      erase_active <= 1'b0; // see R19
      erase_suspended <= 1'b0;
      prog_suspended <= 1'b0;
      flash_dq_oe <= 1'b0;
      flash_ce_b <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      left <= next_left;
      total <= next_total;
      base <= next_base;
      waddr <= next_waddr;
      wdata <= next_wdata;
      gap <= next_gap;
      req_ready <= next_req_ready;
      word_req <= next_word_req;
      done <= next_done;
      refused <= next_refused;
      erase_active <= next_erase_active;
      erase_suspended <= next_erase_suspended;
      prog_suspended <= next_prog_suspended;
      flash_dq_oe <= next_dq_oe;
      flash_ce_b <= next_ce_b;
    end
  end

  // bus outputs straight from registers
  assign flash_addr = waddr;
  assign flash_dq_out = wdata;
  assign flash_we_b = wr_we_b;
endmodule // fpes_host
`default_nettype wire

// File: tb/fpes_host_assertions.sv
/*
  concurrent checks on the flash host pins and request outcome.
  assumes a bind onto fpes_host, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fpes_host_assertions (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic word_req,
  input wire logic done,
  input wire logic refused,
  input wire logic erase_active,
  input wire logic erase_suspended,
  input wire logic prog_suspended,
  input wire logic [fpes_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fpes_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_b,
  input wire logic flash_we_b
);
  import fpes_pkg::*;
  // ---------------------------------------------------------------
  // load phase tracking
  // ---------------------------------------------------------------
  logic in_load;
  logic next_in_load;
  logic we_q;
  logic rst_q;
  // reset seen at the previous edge too, so flops cleared by the asynchronous reset have settled
  always_ff @(posedge ref_clk) begin
    rst_q <= !rst_b;
  end
  // open on the load code, close on the confirm code
  always_comb begin
    next_in_load = in_load;
    if (!we_q && flash_we_b && flash_dq_out == CMD_BITFIELD_LOAD) next_in_load = 1'b1;
    if (!we_q && flash_we_b && flash_dq_out == CMD_BUF_CONFIRM) next_in_load = 1'b0;
  end
  // registers only
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_load <= 1'b0;
      we_q <= 1'b1;
    end else begin
      in_load <= next_in_load;
      we_q <= flash_we_b;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_reset_pins: assert property (
    disable iff (1'b0) !rst_b && rst_q |-> flash_ce_b && flash_we_b && !flash_dq_oe)
    else $error("flash pins active in reset");
  chk_we_framed: assert property (
    !flash_we_b |-> !flash_ce_b && flash_dq_oe)
    else $error("write strobe outside chip enable");
  chk_we_width: assert property (
    $fell(flash_we_b) |-> !flash_we_b [*5] ##1 flash_we_b)
    else $error("write pulse width wrong");
  chk_bus_hold: assert property (
    !flash_we_b && !$fell(flash_we_b) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved in write");
  chk_resv_fill: assert property (
    $rose(flash_we_b) && in_load && flash_addr[RESV_ADDR_BIT] && flash_addr[15:0] != 16'h0aaa
      |-> flash_dq_out == RESERVED_WORD)
    else $error("reserved word not all ones");
  chk_refuse_quiet: assert property (
    refused |-> flash_ce_b && !done ##1 flash_ce_b)
    else $error("refused request reached the pins");
  chk_word_load: assert property (
    word_req |-> in_load && flash_we_b)
    else $error("word asked outside load phase");
  chk_esusp_cause: assert property (
    $rose(erase_suspended) |-> erase_active)
    else $error("erase suspend without erase");
  cover property ($rose(erase_suspended));
  cover property ($rose(prog_suspended));
  cover property (refused);
endmodule // fpes_host_assertions
bind fpes_host fpes_host_assertions u_chk (.ref_clk, .rst_b, .word_req, .done, .refused, .erase_active,
  .erase_suspended, .prog_suspended, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_b, .flash_we_b);
`default_nettype wire

// File: tb/fpes_flash_model.sv
/*
  behavioural flash device: decodes and logs every host write cycle.
  assumes the host alone drives the pins; the model never answers.
*/
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model (
  input wire logic rst_b,
  input wire logic ce_b,
  input wire logic we_b,
  input wire logic [fpes_pkg::ADDR_W-1:0] addr,
  input wire logic [fpes_pkg::DATA_W-1:0] dq
);
  import fpes_pkg::*;
  logic [ADDR_W-1:0] log_a [0:1023];
  logic [DATA_W-1:0] log_d [0:1023];
  logic [SECT_W-1:0] sect;
  logic erasing = 1'b0;
  logic esusp = 1'b0;
  logic psusp = 1'b0;
  logic fail = 1'b0;
  int n_wr = 0;
  int n_ign = 0;
  int left;
  int ph;
  // capture on the rising write strobe, decode by phase
  always @(posedge we_b or negedge rst_b) begin
    if (!rst_b) begin
      ph = 0;
      erasing = 1'b0;
      esusp = 1'b0;
      psusp = 1'b0;
    end else if (!ce_b) begin
      log_a[n_wr] = addr;
      log_d[n_wr] = dq;
      n_wr++;
      if (ph == 2) begin
        if (addr[RESV_ADDR_BIT] && dq !== RESERVED_WORD) fail = 1'b1;
        left--;
        if (left == 0) ph = 3;
      end else if (ph == 1) begin
        left = int'(dq[7:0]) + 1;
        ph = 2;
        if (addr !== {sect, 16'h0aaa}) fail = 1'b1;
      end else if (ph == 3) begin
        ph = 0;
        if (dq !== CMD_BUF_CONFIRM || addr !== {sect, 16'h0555}) fail = 1'b1;
      end else if (ph == 4) begin
        ph = 0;
        if (dq === CMD_SECTOR_ERASE && addr === {sect, 16'h0aaa}) erasing = 1'b1;
        else fail = 1'b1;
      end else if (dq === CMD_PROG_SUSPEND) psusp = 1'b1;
      else if (dq === CMD_PROG_RESUME) psusp = 1'b0;
      else if (dq === CMD_ERASE_SUSPEND && erasing && !esusp) esusp = 1'b1;
      else if (dq === CMD_ERASE_RESUME && esusp) esusp = 1'b0;
      else if (addr[15:0] === 16'h0555 && !psusp && (!erasing || esusp)) begin
        sect = addr[ADDR_W-1-:SECT_W];
        if (dq === CMD_BITFIELD_LOAD) ph = 1;
        else if (dq === CMD_ERASE_SETUP && !erasing) ph = 4;
        else n_ign++;
      end else n_ign++;
    end
  end
endmodule // fpes_flash_model
`default_nettype wire

// File: tb/tb_fpes_host.sv
/*
  self-checking bench for the flash host: program, erase, suspend, resume.
  assumes the flash model logs every completed write cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_fpes_host;
  import fpes_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  fpes_op_t req_op = FPES_OP_PROGRAM;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [CNT_W-1:0] req_count = 9'h001;
  logic [DATA_W-1:0] word_data = '0;
  logic req_ready, word_req, done, refused, erase_active, erase_suspended, prog_suspended;
  logic [ADDR_W-1:0] flash_addr;
  logic [DATA_W-1:0] flash_dq_out;
  logic flash_dq_oe, flash_ce_b, flash_we_b;
  int n_errors = 0;
  int n_compared = 0;
  int nw = 0;
  // ---------------------------------------------------------------
  // clock, parts, word source
  // ---------------------------------------------------------------
  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  fpes_host u_dut (.ref_clk, .rst_b, .req_valid, .req_op, .req_addr, .req_count, .req_ready, .word_req,
    .word_data, .done, .refused, .erase_active, .erase_suspended, .prog_suspended, .flash_addr,
    .flash_dq_out, .flash_dq_oe, .flash_ce_b, .flash_we_b);
  fpes_flash_model u_flash (.rst_b, .ce_b(flash_ce_b), .we_b(flash_we_b), .addr(flash_addr), .dq(flash_dq_out));
  // next program word once asked
  always @(negedge ref_clk) begin
    if (word_req === 1'b1) begin
      word_data = 16'h1000 + 16'(nw);
      nw++;
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk({flash_ce_b, flash_we_b, flash_dq_oe, req_ready}, 48'hc);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic req(input fpes_op_t op, input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] n,
    output logic rf);
    int k;
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_count = n;
    k = 0;
    while (req_ready !== 1'b1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    k = 0;
    while (done !== 1'b1 && refused !== 1'b1 && k < 4000) begin
      @(negedge ref_clk);
      k++;
    end
    rf = refused;
    if (k == 4000) chk(k, 0);
    @(negedge ref_clk);
  endtask
  task automatic t_prog(input logic [ADDR_W-1:0] b, input int n);
    int w;
    logic rf;
    logic [ADDR_W-1:0] a;
    w = u_flash.n_wr;
    nw = 0;
    req(FPES_OP_PROGRAM, b, CNT_W'(n), rf);
    chk({rf, u_flash.n_wr - w}, n + 3);
    chk({u_flash.log_a[w], u_flash.log_d[w]}, {b + FIRST_CMD_OFS, CMD_BITFIELD_LOAD});
    chk({u_flash.log_a[w+1], u_flash.log_d[w+1]}, {b + SECOND_CMD_OFS, 16'(n - 1)});
    for (int i = 0; i < n; i++) begin
      a = b + ADDR_W'(i);
      chk({u_flash.log_a[w+2+i], u_flash.log_d[w+2+i]},
        {a, a[RESV_ADDR_BIT] ? RESERVED_WORD : 16'h1000 + 16'(i)});
    end
    chk({u_flash.log_a[w+n+2], u_flash.log_d[w+n+2]}, {b + FIRST_CMD_OFS, CMD_BUF_CONFIRM});
  endtask
  task automatic t_one(input fpes_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic rf_exp);
    int w;
    logic rf;
    w = u_flash.n_wr;
    req(op, a, 9'h004, rf);
    chk({rf, u_flash.n_wr - w}, {rf_exp, rf_exp ? 32'h0 : 32'h1});
    if (!rf_exp) chk({u_flash.log_a[w], u_flash.log_d[w]}, {a, d});
  endtask
  task automatic t_erase(input logic [ADDR_W-1:0] b);
    int w;
    logic rf;
    w = u_flash.n_wr;
    req(FPES_OP_ERASE, b, 9'h001, rf);
    chk({rf, u_flash.log_d[w], u_flash.log_d[w+1], erase_active},
      {1'b0, CMD_ERASE_SETUP, CMD_SECTOR_ERASE, 1'b1});
    chk({u_flash.log_a[w], u_flash.log_a[w+1]}, {b + FIRST_CMD_OFS, b + SECOND_CMD_OFS});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_prog_suspend;
    repeat (RESUME_GAP_CYC + 10) @(negedge ref_clk);
    t_one(FPES_OP_PRESUME, 24'h000010, CMD_PROG_RESUME, 1'b1);
    t_one(FPES_OP_PSUSPEND, 24'h5a5a5a, CMD_PROG_SUSPEND, 1'b0);
    chk(prog_suspended, 1);
    t_one(FPES_OP_PROGRAM, 24'h030000, 16'h0, 1'b1);
    t_one(FPES_OP_PRESUME, 24'hc3c3c3, CMD_PROG_RESUME, 1'b0);
    chk(prog_suspended, 0);
    t_one(FPES_OP_PSUSPEND, 24'h000000, CMD_PROG_SUSPEND, 1'b1);
    t_one(FPES_OP_PRESUME, 24'h000000, CMD_PROG_RESUME, 1'b1);
  endtask
  task automatic sc_erase_suspend;
    do_reset;
    t_erase(24'h050000);
    t_one(FPES_OP_ERASE, 24'h050000, 16'h0, 1'b1);
    t_one(FPES_OP_PROGRAM, 24'h030000, 16'h0, 1'b1);
    t_one(FPES_OP_ERESUME, 24'h000000, CMD_ERASE_RESUME, 1'b1);
    repeat (RESUME_GAP_CYC + 10) @(negedge ref_clk);
    t_one(FPES_OP_ESUSPEND, 24'habcdef, CMD_ERASE_SUSPEND, 1'b0);
    chk(erase_suspended, 1);
    t_prog(24'h060000, 4);
    chk(erase_suspended, 1);
    t_one(FPES_OP_ERESUME, 24'h000008, CMD_ERASE_RESUME, 1'b0);
    chk(erase_suspended, 0);
    t_one(FPES_OP_ESUSPEND, 24'h000000, CMD_ERASE_SUSPEND, 1'b1);
    t_one(FPES_OP_ERESUME, 24'h000000, CMD_ERASE_RESUME, 1'b1);
  endtask
  task automatic sc_reset_erase;
    do_reset;
    chk(erase_active, 0);
    t_erase(24'h050000);
    chk({u_flash.fail, u_flash.n_ign}, 0);
  endtask
  // watchdog well beyond the expected run
  initial begin
    #(80000 * CLK_PERIOD_NS);
    n_errors++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    do_reset;
    t_prog(24'h030000, 12);
    t_prog(24'h040000, 256);
    sc_prog_suspend;
    sc_erase_suspend;
    sc_reset_erase;
    tally_and_finish;
  end
endmodule // tb_fpes_host
`default_nettype wire
